// ### hdl/rvip_top.sv
// The Avalon-MM interface to the registers was chosen for this implementation.
`include "rvip_cfg.svh"
`default_nettype none
module rvip_top #(
   parameter logic [15:0] VEC_SWI = 16'hfff6,
   parameter logic [15:0] VEC_ILLEGAL = 16'hfff8,
   parameter int unsigned NUM_SRC = 15
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic porCause,
   input wire logic clkMonCause,
   input wire logic watchdogCause,
   input wire logic modePinA,
   input wire logic modePinB,
   input wire logic watchdogDisable,
   input wire logic [15:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic flagsWrite,
   input wire logic [2:0] flagsIn,
   input wire logic nonmaskablePinInterrupt,
   input wire logic illegalOpcode,
   input wire logic softwareInterrupt,
   input wire logic [NUM_SRC-1:0] maskReq,
   input wire logic [NUM_SRC-1:0] maskEnable,
   output logic xMask,
   output logic iMask,
   output logic stopDisable,
   output logic [15:0] fetchAddr,
   output logic fetchValid,
   output logic cpuRun,
   output logic [1:0] resetCause,
   output logic intReq,
   output logic [15:0] intVector,
   output logic [4:0] intSource,
   output logic bootRomRead,
   output logic specialModeBit,
   output logic modeABit,
   output logic readVisibility,
   output logic [7:0] memInit,
   output logic irqEdgeSense,
   output logic stopRecoveryDelay,
   output logic clockMonitorEnable,
   output logic adcPowerUp,
   output logic adcClockSelect,
   output logic watchdogEnable,
   output logic [1:0] watchdogRate,
   output logic periphInit,
   output logic [15:0] timerCountLoad,
   output logic [15:0] compareLoad,
   output logic [7:0] baudLoad,
   output logic [7:0] sciStatusLoad
);
   import rvip_pkg::*;

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      rvip_phase_t phase;
      logic lastReset;
      logic [2:0] causeSeen;
      rvip_cause_t cause;
      logic xMask;
      logic iMask;
      logic stopDisable;
      logic boot;
      logic spec;
      logic modeA;
      logic irv;
      logic [3:0] psel;
      logic adpu;
      logic csel;
      logic irqEdge;
      logic stopDelay;
      logic cmon;
      logic [1:0] wdRate;
      logic optLocked;
      logic [6:0] cycleCount;
      logic [7:0] memInit;
      logic wdEnable;
      logic periphInit;
      logic waitReq;
      logic [31:0] readData;
      logic [15:0] fetchAddr;
      logic fetchValid;
      logic cpuRun;
      logic intReq;
      logic [15:0] intVector;
      logic [4:0] intSource;
      logic [15:0] timerLoad;
      logic [15:0] compareLoad;
      logic [7:0] baudLoad;
      logic [7:0] sciLoad;
   } rvip_state_t;

   rvip_state_t st;
   rvip_state_t next_st;

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic addrIs(input logic [15:0] addr, input logic [13:0] idx);
      addrIs = (addr[15:2] == idx);
   endfunction : addrIs

   function automatic logic [15:0] causeVector(input rvip_cause_t c, input logic special);
      unique case (c)
         CAUSE_CLKMON: causeVector = special ? `RVIP_VEC_SPEC_CLKMON : `RVIP_VEC_CLKMON;
         CAUSE_WDOG: causeVector = special ? `RVIP_VEC_SPEC_WDOG : `RVIP_VEC_WDOG;
         default: causeVector = special ? `RVIP_VEC_SPEC_POR : `RVIP_VEC_POR;
      endcase
   endfunction : causeVector

   logic [2:0] causesNow;
   logic [2:0] causesAll;
   logic [NUM_SRC-1:0] maskLive;
   logic maskHit;
   logic [3:0] maskIndex;
   logic [7:0] pmRead;
   logic [7:0] optionRead;
   logic optTimed;

   assign causesNow = {watchdogCause, clkMonCause, porCause};
   assign causesAll = causesNow | st.causeSeen;
   assign maskLive = maskReq & maskEnable; // R13

   rvip_prio_enc #(
      .NUM_SRC(NUM_SRC)
   ) u_prio (
      .req(maskLive),
      .psel(st.psel),
      .hit(maskHit),
      .index(maskIndex)
   );

   // ****************************************
   // Register read view
   // ****************************************
   always_comb begin
      pmRead = {st.boot & st.spec, st.spec, st.modeA, st.irv, st.psel}; // R20
      optionRead = {st.adpu, st.csel, st.irqEdge, st.stopDelay, st.cmon, 1'b0, st.wdRate};
      optTimed = st.spec || (!st.optLocked && (st.cycleCount < `RVIP_OPT_WINDOW));
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_st = st;
      next_st.lastReset = reset;
      if (reset) begin
         next_st.phase = PH_RESET;
         next_st.causeSeen = causesNow | (st.causeSeen & {3{st.lastReset}}); // R25
         next_st.cause = CAUSE_POR;
         next_st.xMask = 1'b1; // R4
         next_st.iMask = 1'b1; // R4
         next_st.stopDisable = 1'b1; // R4
         next_st.boot = 1'b0;
         next_st.spec = 1'b0;
         next_st.modeA = 1'b0;
         next_st.irv = 1'b0;
         next_st.psel = `RVIP_PSEL_RST; // R16
         next_st.adpu = 1'b0;
         next_st.csel = 1'b0;
         next_st.irqEdge = 1'b0; // R17
         next_st.stopDelay = 1'b1; // R22
         next_st.cmon = 1'b0; // R22
         next_st.wdRate = 2'h0; // R8
         next_st.optLocked = 1'b0;
         next_st.cycleCount = 7'h00;
         next_st.memInit = `RVIP_INIT_RST; // R5
         next_st.wdEnable = 1'b0;
         next_st.periphInit = 1'b1; // R6 R7 R9
         next_st.waitReq = 1'b1;
         next_st.readData = 32'h0000_0000;
         next_st.fetchAddr = 16'h0000;
         next_st.fetchValid = 1'b0;
         next_st.cpuRun = 1'b0;
         next_st.intReq = 1'b0;
         next_st.intVector = 16'h0000;
         next_st.intSource = `RVIP_SRC_NONE;
         next_st.timerLoad = `RVIP_TIMER_RST; // R6
         next_st.compareLoad = `RVIP_COMPARE_RST; // R6
         next_st.baudLoad = `RVIP_BAUD_RST; // R9
         next_st.sciLoad = `RVIP_SCI_STATUS_RST; // R9
      end else begin
         next_st.causeSeen = 3'h0;
         if (st.cycleCount < `RVIP_OPT_WINDOW) begin
            next_st.cycleCount = st.cycleCount + 7'h01;
         end

         // Release, vector fetch and start
         unique case (st.phase)
            PH_RESET: begin
               if (causesAll[0]) begin
                  next_st.cause = CAUSE_POR; // R10 R25
               end else if (causesAll[1]) begin
                  next_st.cause = CAUSE_CLKMON; // R10 R25
               end else if (causesAll[2]) begin
                  next_st.cause = CAUSE_WDOG; // R10 R25
               end else begin
                  next_st.cause = CAUSE_POR;
               end
               next_st.spec = ~modePinB; // R18 R19
               next_st.modeA = modePinA; // R18 R24
               next_st.boot = ~modePinB & ~modePinA; // R18
               next_st.irv = ~modePinB & modePinA; // R18
               next_st.wdEnable = ~watchdogDisable; // R8
               next_st.fetchAddr = causeVector(next_st.cause, ~modePinB); // R1 R2
               next_st.fetchValid = 1'b1; // R3
               next_st.periphInit = 1'b0;
               next_st.phase = PH_FETCH_HI;
            end
            PH_FETCH_HI: begin
               next_st.fetchAddr = {st.fetchAddr[15:1], 1'b1}; // R3
               next_st.phase = PH_FETCH_LO;
            end
            PH_FETCH_LO: begin
               next_st.fetchValid = 1'b0;
               next_st.cpuRun = 1'b1; // R3
               next_st.phase = PH_RUN;
            end
            PH_RUN: begin
               next_st.cpuRun = 1'b1;
            end
         endcase

         // Flags kept by the core
         if (flagsWrite) begin
            next_st.xMask = flagsIn[2];
            next_st.iMask = flagsIn[1];
            next_st.stopDisable = flagsIn[0];
         end

         // Interrupt resolution
         next_st.intReq = 1'b1;
         if (nonmaskablePinInterrupt && !st.xMask) begin
            next_st.intVector = `RVIP_VEC_NMI; // R10
            next_st.intSource = `RVIP_SRC_NMI;
         end else if (illegalOpcode) begin
            next_st.intVector = VEC_ILLEGAL; // R10
            next_st.intSource = `RVIP_SRC_ILLEGAL;
         end else if (softwareInterrupt) begin
            next_st.intVector = VEC_SWI; // R10
            next_st.intSource = `RVIP_SRC_SOFT;
         end else if (maskHit && !st.iMask) begin
            next_st.intVector = `RVIP_VEC_IRQ - {11'h000, maskIndex, 1'b0}; // R13 R14
            next_st.intSource = `RVIP_SRC_MASKABLE | {1'b0, maskIndex};
         end else begin
            next_st.intReq = 1'b0;
            next_st.intVector = 16'h0000;
            next_st.intSource = `RVIP_SRC_NONE;
         end

         // Avalon slave, one wait cycle
         if (st.waitReq && (avs_read || avs_write)) begin
            next_st.waitReq = 1'b0;
            next_st.readData = 32'h0000_0000;
            if (avs_read) begin
               if (addrIs(avs_address, `RVIP_IDX_PMISC)) begin
                  next_st.readData = {24'h000000, pmRead};
               end else if (addrIs(avs_address, `RVIP_IDX_OPTION)) begin
                  next_st.readData = {24'h000000, optionRead};
               end else if (addrIs(avs_address, `RVIP_IDX_INIT)) begin
                  next_st.readData = {24'h000000, st.memInit};
               end else if (addrIs(avs_address, `RVIP_IDX_STATUS)) begin
                  next_st.readData = {26'h0000000, st.wdEnable, st.cpuRun,
                     st.phase, st.cause};
               end
            end
         end else if (!st.waitReq) begin
            next_st.waitReq = 1'b1;
            if (avs_write && avs_byteenable[0]) begin
               if (addrIs(avs_address, `RVIP_IDX_PMISC) && st.iMask) begin // R15
                  next_st.psel = avs_writedata[3:0]; // R12
                  next_st.irv = avs_writedata[`RVIP_HP_IRV];
                  if (st.spec) begin
                     next_st.boot = avs_writedata[`RVIP_HP_BOOT]; // R20
                     next_st.spec = avs_writedata[`RVIP_HP_SPEC]; // R21
                     next_st.modeA = avs_writedata[`RVIP_HP_MODEA]; // R21
                  end
               end else if (addrIs(avs_address, `RVIP_IDX_OPTION)) begin
                  next_st.adpu = avs_writedata[`RVIP_OPT_ADPU];
                  next_st.csel = avs_writedata[`RVIP_OPT_CSEL];
                  next_st.cmon = avs_writedata[`RVIP_OPT_CMON];
                  if (optTimed) begin
                     next_st.irqEdge = avs_writedata[`RVIP_OPT_IRQE];
                     next_st.stopDelay = avs_writedata[`RVIP_OPT_DELAY];
                     next_st.wdRate = avs_writedata[1:0];
                     next_st.optLocked = ~st.spec;
                  end
               end else if (addrIs(avs_address, `RVIP_IDX_INIT)) begin
                  next_st.memInit = avs_writedata[7:0];
               end
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      st <= next_st;
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign avs_readdata = st.readData;
   assign avs_waitrequest = st.waitReq;
   assign xMask = st.xMask;
   assign iMask = st.iMask;
   assign stopDisable = st.stopDisable;
   assign fetchAddr = st.fetchAddr;
   assign fetchValid = st.fetchValid;
   assign cpuRun = st.cpuRun;
   assign resetCause = st.cause;
   assign intReq = st.intReq;
   assign intVector = st.intVector;
   assign intSource = st.intSource;
   assign bootRomRead = st.boot;
   assign specialModeBit = st.spec;
   assign modeABit = st.modeA;
   assign readVisibility = st.irv;
   assign memInit = st.memInit;
   assign irqEdgeSense = st.irqEdge;
   assign stopRecoveryDelay = st.stopDelay;
   assign clockMonitorEnable = st.cmon;
   assign adcPowerUp = st.adpu;
   assign adcClockSelect = st.csel;
   assign watchdogEnable = st.wdEnable;
   assign watchdogRate = st.wdRate;
   assign periphInit = st.periphInit;
   assign timerCountLoad = st.timerLoad;
   assign compareLoad = st.compareLoad;
   assign baudLoad = st.baudLoad;
   assign sciStatusLoad = st.sciLoad;
endmodule : rvip_top
`default_nettype wire

// ### hdl/rvip_cfg.svh
// Notes on behaviour
// R1: Normal modes take the reset vector at FFFE, FFFC or FFFA by cause.
// R2: Special test or bootstrap modes take the vector at BFFE, BFFC or BFFA instead.
// R3: The restart vector is fetched within three cycles after reset, then execution starts.
// R4: Reset sets the X mask, I mask and stop-disable flags.
// R5: Reset loads the memory placement register with 01.
// R6: Reset clears the timer, sets compares to FFFF, clears timer flags and masks.
// R7: Reset clears the periodic flag, its enable and rate, and disables the accumulator.
// R8: The watchdog is enabled unless its disable bit is set, at the shortest rate.
// R9: Reset sets baud to 04, 8-bit frames, serial off, transmit flags set.
// R10: Non-maskable ranking: resets first, then pin interrupt, illegal opcode, software interrupt.
// R11: Fifteen maskable sources have a fixed default ranking, external request first.
// R12: The selected maskable source is raised to the top; others keep their order.
// R13: A promoted source is still blocked by the global mask and its local enable.
// R14: Priority changes never change any source's vector address.
// R15: The priority register accepts writes only while the global mask is set.
// R16: Reset loads the priority select field with 0110, the external request.
// R17: Out of reset the external request pin is level sensitive.
// R18: At reset release both mode pins are latched into the mode bits.
// R19: The special-mode bit holds mode pin B inverted, sampled at reset release.
// R20: The boot-ROM bit is writable only in special mode and reads zero otherwise.
// R21: In special modes, writing the mode bits switches the operating mode.
// R22: Reset sets the stop-recovery delay bit and clears the clock monitor enable.
// R23: Select codes map 0000 timer overflow to 1111 capture4; 0101 acts as 0110.
// R24: The mode-A bit holds mode pin A, sampled at reset release.
// R25: At reset release the highest active cause alone selects the vector pair.
`ifndef RVIP_CFG_SVH
`define RVIP_CFG_SVH
`define RVIP_IDX_OPTION 14'h1039
`define RVIP_IDX_PMISC 14'h103c
`define RVIP_IDX_INIT 14'h1040
`define RVIP_IDX_STATUS 14'h1041
`define RVIP_VEC_POR 16'hfffe
`define RVIP_VEC_CLKMON 16'hfffc
`define RVIP_VEC_WDOG 16'hfffa
`define RVIP_VEC_SPEC_POR 16'hbffe
`define RVIP_VEC_SPEC_CLKMON 16'hbffc
`define RVIP_VEC_SPEC_WDOG 16'hbffa
`define RVIP_VEC_NMI 16'hfff4
`define RVIP_VEC_IRQ 16'hfff2
`define RVIP_INIT_RST 8'h01
`define RVIP_PSEL_RST 4'h6
`define RVIP_TIMER_RST 16'h0000
`define RVIP_COMPARE_RST 16'hffff
`define RVIP_BAUD_RST 8'h04
`define RVIP_SCI_STATUS_RST 8'hc0
`define RVIP_OPT_WINDOW 7'h40
`define RVIP_HP_BOOT 7
`define RVIP_HP_SPEC 6
`define RVIP_HP_MODEA 5
`define RVIP_HP_IRV 4
`define RVIP_OPT_ADPU 7
`define RVIP_OPT_CSEL 6
`define RVIP_OPT_IRQE 5
`define RVIP_OPT_DELAY 4
`define RVIP_OPT_CMON 3
`define RVIP_SRC_NONE 5'h00
`define RVIP_SRC_NMI 5'h01
`define RVIP_SRC_ILLEGAL 5'h02
`define RVIP_SRC_SOFT 5'h03
`define RVIP_SRC_MASKABLE 5'h10
`endif

// ### hdl/rvip_pkg.sv
`default_nettype none
package rvip_pkg;
   typedef enum logic [1:0] {PH_RESET, PH_FETCH_HI, PH_FETCH_LO, PH_RUN} rvip_phase_t;
   typedef enum logic [1:0] {CAUSE_POR, CAUSE_CLKMON, CAUSE_WDOG} rvip_cause_t;
endpackage : rvip_pkg
`default_nettype wire

// ### hdl/rvip_prio_enc.sv
`default_nettype none
module rvip_prio_enc #(
   parameter int unsigned NUM_SRC = 15
) (
   input wire logic [NUM_SRC-1:0] req,
   input wire logic [3:0] psel,
   output logic hit,
   output logic [3:0] index
);
   // ****************************************
   // Select code to default-order index
   // ****************************************
   function automatic logic [3:0] pselToIndex(input logic [3:0] code);
      unique case (code)
         4'h0: pselToIndex = 4'ha; // R23
         4'h1: pselToIndex = 4'hb;
         4'h2: pselToIndex = 4'hc;
         4'h3: pselToIndex = 4'hd;
         4'h4: pselToIndex = 4'he;
         4'h5, 4'h6: pselToIndex = 4'h0; // R23
         4'h7: pselToIndex = 4'h1;
         4'h8: pselToIndex = 4'h2;
         4'h9: pselToIndex = 4'h3;
         4'ha: pselToIndex = 4'h4;
         4'hb: pselToIndex = 4'h5;
         4'hc: pselToIndex = 4'h6;
         4'hd: pselToIndex = 4'h7;
         4'he: pselToIndex = 4'h8;
         4'hf: pselToIndex = 4'h9;
      endcase
   endfunction : pselToIndex

   logic [3:0] promoted;

   always_comb begin
      promoted = pselToIndex(psel);
      hit = |req;
      index = 4'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            index = 4'(i); // R11
         end
      end
      if (req[promoted]) begin
         index = promoted; // R12
      end
   end
endmodule : rvip_prio_enc
`default_nettype wire

// ### bench/rvip_cpu_model.sv
`default_nettype none
module rvip_cpu_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic fetchValid,
   input wire logic [15:0] fetchAddr,
   input wire logic setFlags,
   input wire logic [2:0] flagsReq,
   output var logic flagsWrite = 1'h0,
   output var logic [2:0] flagsIn = 3'h0,
   output logic [15:0] restartAddr,
   output logic pairOk
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // Core side: takes the vector pair, loads flags on command
   // ****************
   always @(posedge clk) begin
      flagsWrite <= setFlags;
      flagsIn <= setFlags ? flagsReq : ~flagsIn;
      if (reset)
         pairOk <= 1'h0;
      else if (fetchValid && fetchAddr[0])
         pairOk <= fetchAddr == (restartAddr | 16'h0001);
      if (fetchValid && !fetchAddr[0])
         restartAddr <= fetchAddr;
   end
endmodule : rvip_cpu_model
`default_nettype wire

// ### bench/rvip_top_asserts.sv
`default_nettype none
module rvip_top_asserts #(
   parameter int unsigned NUM_SRC = 15
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic porCause,
   input wire logic clkMonCause,
   input wire logic watchdogCause,
   input wire logic modePinA,
   input wire logic modePinB,
   input wire logic watchdogDisable,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic nonmaskablePinInterrupt,
   input wire logic [NUM_SRC-1:0] maskReq,
   input wire logic [NUM_SRC-1:0] maskEnable,
   input wire logic xMask,
   input wire logic iMask,
   input wire logic stopDisable,
   input wire logic [15:0] fetchAddr,
   input wire logic fetchValid,
   input wire logic cpuRun,
   input wire logic [1:0] resetCause,
   input wire logic intReq,
   input wire logic [15:0] intVector,
   input wire logic [4:0] intSource,
   input wire logic bootRomRead,
   input wire logic specialModeBit,
   input wire logic modeABit,
   input wire logic watchdogEnable,
   input wire logic periphInit,
   input wire logic [15:0] timerCountLoad,
   input wire logic [15:0] compareLoad,
   input wire logic [7:0] baudLoad,
   input wire logic [7:0] sciStatusLoad
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************
   // Reset and interrupt checks
   // ****************
   logic prevI;
   logic [NUM_SRC-1:0] prevReq;
   always_ff @(posedge clk) begin
      prevI <= iMask;
      prevReq <= maskReq & maskEnable;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);
   sequence s_fetch_hi;
      fetchValid && !fetchAddr[0] && !cpuRun;
   endsequence
   sequence s_fetch_lo;
      fetchValid && fetchAddr[0] && !cpuRun;
   endsequence
   a_restart_fetch: assert property (
      $fell(reset) |=> s_fetch_hi ##1 s_fetch_lo ##1 (!fetchValid && cpuRun))
      else $error("restart fetch out of order");
   a_restart_vector: assert property (
      s_fetch_hi |-> fetchAddr == {(specialModeBit ? 8'hbf : 8'hff), 8'hfe - {5'h00, resetCause, 1'h0}})
      else $error("restart vector address wrong");
   a_cause_rank: assert property ($fell(reset) |=> resetCause ==
      ($past(porCause) ? 2'h0 : $past(clkMonCause) ? 2'h1 : $past(watchdogCause) ? 2'h2 : 2'h0))
      else $error("reset cause not highest");
   a_reset_state: assert property ($fell(reset) |-> xMask && iMask && stopDisable
      && periphInit && timerCountLoad == 16'h0000 && compareLoad == 16'hffff
      && baudLoad == 8'h04 && sciStatusLoad == 8'hc0 ##1 !periphInit)
      else $error("reset state wrong");
   a_mode_latch: assert property ($fell(reset) |=> specialModeBit == !$past(modePinB)
      && modeABit == $past(modePinA) && bootRomRead == (!$past(modePinB) && !$past(modePinA)))
      else $error("mode bits not latched");
   a_watchdog_init: assert property (
      $fell(reset) && modePinB |=> watchdogEnable == !$past(watchdogDisable))
      else $error("watchdog enable wrong");
   a_boot_clear: assert property (!specialModeBit |-> !bootRomRead)
      else $error("boot bit set outside special mode");
   a_bus_answer: assert property (
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus answer timing wrong");
   a_mask_gate: assert property (
      intReq && intSource[4] |-> !prevI && prevReq[intSource[3:0]])
      else $error("masked source granted");
   a_mask_vector: assert property (
      intReq && intSource[4] |-> intVector == 16'hfff2 - {11'h000, intSource[3:0], 1'h0})
      else $error("maskable vector wrong");
   a_pin_first: assert property ($past(nonmaskablePinInterrupt) && !$past(xMask)
      |-> intReq && intSource == 5'h01 && intVector == 16'hfff4)
      else $error("pin interrupt not first");
endmodule : rvip_top_asserts
bind rvip_top rvip_top_asserts #(.NUM_SRC(NUM_SRC)) chk (.*);
`default_nettype wire

// ### bench/tb_reset_vector_and_interrupt_priority.sv
`default_nettype none
module tb_reset_vector_and_interrupt_priority;
   timeunit 1ns;
   timeprecision 100ps;
   // ****************
   // Stimulus and checks
   // ****************
   logic clk = 1'h0, reset = 1'h1, porCause = 1'h1, clkMonCause = 1'h0, watchdogCause = 1'h0;
   logic modePinA = 1'h0, modePinB = 1'h1, watchdogDisable = 1'h0, setFlags = 1'h0;
   logic avs_read = 1'h0, avs_write = 1'h0, nonmaskablePinInterrupt = 1'h0;
   logic illegalOpcode = 1'h0, softwareInterrupt = 1'h0;
   logic [15:0] avs_address = 16'h0000;
   logic [31:0] avs_writedata = 32'h0, avs_readdata;
   logic [3:0] avs_byteenable = 4'hf;
   logic [2:0] flagsIn, flagsReq = 3'h7;
   logic [14:0] maskReq = 15'h0, maskEnable = 15'h0;
   logic avs_waitrequest, flagsWrite, xMask, iMask, stopDisable, fetchValid, cpuRun, intReq;
   logic bootRomRead, specialModeBit, modeABit, readVisibility, irqEdgeSense, stopRecoveryDelay;
   logic clockMonitorEnable, adcPowerUp, adcClockSelect, watchdogEnable, periphInit, pairOk;
   logic [15:0] fetchAddr, intVector, timerCountLoad, compareLoad, restartAddr;
   logic [1:0] resetCause, watchdogRate;
   logic [4:0] intSource;
   logic [7:0] memInit, baudLoad, sciStatusLoad;
   int nErrors = 0, comparisons = 0, cycles = 0;
   rvip_top uut (.clk, .reset, .porCause, .clkMonCause, .watchdogCause, .modePinA, .modePinB,
      .watchdogDisable, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .flagsWrite, .flagsIn, .nonmaskablePinInterrupt,
      .illegalOpcode, .softwareInterrupt, .maskReq, .maskEnable, .xMask, .iMask, .stopDisable,
      .fetchAddr, .fetchValid, .cpuRun, .resetCause, .intReq, .intVector, .intSource,
      .bootRomRead, .specialModeBit, .modeABit, .readVisibility, .memInit, .irqEdgeSense,
      .stopRecoveryDelay, .clockMonitorEnable, .adcPowerUp, .adcClockSelect, .watchdogEnable,
      .watchdogRate, .periphInit, .timerCountLoad, .compareLoad, .baudLoad, .sciStatusLoad);
   rvip_cpu_model cpu (.clk, .reset, .fetchValid, .fetchAddr, .setFlags, .flagsReq,
      .flagsWrite, .flagsIn, .restartAddr, .pairOk);
   initial begin
      forever #12.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         nErrors++;
         conclude();
      end
   end
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", comparisons, nErrors);
      if (nErrors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : conclude
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         nErrors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d,
                      input logic [7:0] exp);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      avs_write <= wr;
      avs_read <= !wr;
      do
         @(posedge clk);
      while (avs_waitrequest !== 1'h0);
      check("answer", 1'h0, avs_waitrequest);
      if (!wr)
         check("readdata", {24'h000000, exp}, avs_readdata);
      avs_write <= 1'h0;
      avs_read <= 1'h0;
   endtask : bus
   task automatic set_flags(input logic [2:0] v);
      @(posedge clk);
      flagsReq <= v;
      setFlags <= 1'h1;
      @(posedge clk);
      setFlags <= 1'h0;
      repeat (2) @(posedge clk);
      #1;
      check("flags", v, {xMask, iMask, stopDisable});
   endtask : set_flags
   task automatic irq(input logic [2:0] nm, input logic [14:0] req, input logic [14:0] en,
                      input int src);
      @(posedge clk);
      {nonmaskablePinInterrupt, illegalOpcode, softwareInterrupt} <= nm;
      maskReq <= req;
      maskEnable <= en;
      repeat (2) @(posedge clk);
      #1;
      check("intSource", {src != 0, 5'(src)}, {intReq, intSource});
      if (src != 0)
         check("intVector", src == 1 ? 16'hfff4 : src == 2 ? 16'hfff8 : src == 3 ? 16'hfff6
            : 16'hfff2 - 16'(2 * (src - 16)), intVector);
   endtask : irq
   task automatic do_reset(input int k);
      logic [7:0] lo;
      lo = k == 1 ? 8'hfc : k == 2 ? 8'hfa : 8'hfe;
      @(posedge clk);
      reset <= 1'h1;
      modePinA <= k[0];
      modePinB <= !k[1];
      watchdogDisable <= k[0];
      porCause <= k == 0 || k == 3;
      clkMonCause <= k == 1;
      watchdogCause <= k == 1 || k == 2;
      repeat (12) @(posedge clk);
      reset <= 1'h0;
      repeat (2) @(posedge clk);
      {porCause, clkMonCause, watchdogCause} <= 3'h0;
      repeat (3) @(posedge clk);
      #1;
      check("restart", {(k[1] ? 8'hbf : 8'hff), lo}, restartAddr);
      check("pair", {1'h1, 1'h1}, {pairOk, cpuRun});
      check("resetFlags", 3'h7, {xMask, iMask, stopDisable});
      check("memInit", 8'h01, memInit);
      check("option", 4'h4, {irqEdgeSense, stopRecoveryDelay, clockMonitorEnable, adcPowerUp});
      if (!k[1])
         check("watchdog", {!k[0], 2'h0}, {watchdogEnable, watchdogRate});
      bus(1'h0, 16'h40f0, 8'h00, {k == 2, k[1], k[0], k == 3, 4'h6});
   endtask : do_reset
   initial begin
      int rank;
      for (int k = 0; k < 4; k++)
         do_reset(k);
      bus(1'h1, 16'h40f0, 8'hc6, 8'h00);
      bus(1'h0, 16'h40f0, 8'h00, 8'hc6);
      check("modes", 3'h6, {bootRomRead, specialModeBit, modeABit});
      bus(1'h1, 16'h40f0, 8'h06, 8'h00);
      bus(1'h1, 16'h40f0, 8'h86, 8'h00);
      bus(1'h0, 16'h40f0, 8'h00, 8'h06);
      bus(1'h0, 16'h0000, 8'h00, 8'h00);
      do_reset(0);
      irq(3'h4, 15'h7fff, 15'h7fff, 0);
      set_flags(3'h1);
      irq(3'h7, 15'h7fff, 15'h7fff, 1);
      irq(3'h3, 15'h7fff, 15'h7fff, 2);
      irq(3'h1, 15'h7fff, 15'h7fff, 3);
      for (int i = 0; i < 15; i++)
         irq(3'h0, 15'h4000 | (15'h0001 << i), 15'h7fff, 16 + i);
      irq(3'h0, 15'h7fff, 15'h7ffe, 17);
      bus(1'h1, 16'h40f0, 8'h00, 8'h00);
      bus(1'h0, 16'h40f0, 8'h00, 8'h06);
      for (int c = 0; c < 16; c++) begin
         rank = c < 5 ? 10 + c : c < 7 ? 0 : c - 6;
         set_flags(3'h3);
         bus(1'h1, 16'h40f0, 8'(c), 8'h00);
         if (c != 5)
            bus(1'h0, 16'h40f0, 8'h00, 8'(c));
         set_flags(3'h1);
         irq(3'h0, 15'h7fff, 15'h7fff, 16 + rank);
         irq(3'h0, 15'h7fff, ~(15'h0001 << rank), rank == 0 ? 17 : 16);
      end
      conclude();
   end
endmodule : tb_reset_vector_and_interrupt_priority
`default_nettype wire
